// ==== src/tmr_timer16.sv ====
// 16-bit timer with shared high-byte access and prescaler sync control
// Functional notes
// - Hold mode keeps written prescaler reset bits
// - Clearing hold mode clears both reset bits
// - Sync reset bit resets prescaler, self-clears outside hold mode
// - Counter, compares, capture are 16 bits
// - Flags visible, each request individually masked
// - Tick from prescaler or external pin
// - Compare match sets flag, drives waveform
// - Edge event captures counter through filter
// - Compare A as TOP in TMR_MODE_FPWM_CMP: buffered, no output
// - All zeros is BOTTOM
// - All ones is MAX
// - TOP from fixed values, compare A, capture
// - One shared high-byte holding register
// - Low write loads held high plus low
// - Counter or capture low read copies high into holding register
// - Compare high reads bypass holding register
// - Clock select zero stops counter, still accessible
// - CPU counter write beats clear or count
// - Prescaler free running, taps 8/64/256/1024
`include "tmr_defs.svh"
module tmr_timer16 (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // CPU I/O port
    input  tmr_pkg::tmr_io_req_t      io_req,
    output logic [7:0]                io_rdata,
    // Pins and system inputs
    input  wire logic                 external_count_pin,
    input  wire logic                 capture_input_pin,
    input  wire logic                 comparator_out,
    input  wire logic                 capture_use_comparator,
    input  wire logic                 timer_power_off,
    // Waveform outputs
    output logic                      waveform_out_a,
    output logic                      waveform_out_b,
    // Masked requests: capture, compare B, compare A, overflow
    output logic [3:0]                irq_req,
    // Prescaler reset levels
    output logic                      sync_prescaler_rst,
    output logic                      async_prescaler_rst
);
    tmr_pkg::tmr_word_t counter_value;
    tmr_pkg::tmr_word_t capture_value;
    tmr_pkg::tmr_word_t compare_buf [2];
    tmr_pkg::tmr_word_t compare_act [2];
    tmr_pkg::tmr_word_t next_counter;
    tmr_pkg::tmr_word_t top_value;
    logic [7:0]         timer_control_a;
    logic [7:0]         timer_control_b;
    logic [7:0]         timer_flag_register;
    logic [7:0]         timer_mask_register;
    logic [7:0]         high_hold;
    logic [7:0]         next_flag;
    logic [7:0]         read_data;
    logic               sync_hold_mode;
    logic [1:0]         wave;
    logic [1:0]         cmp_match;
    logic [3:0]         tap_tick;
    logic [2:0]         ext_sync;

    // Address decode
    wire wr = io_req.wr;
    wire rd = io_req.rd;
    wire sel_cnt_l  = io_req.addr == `TMR_ADDR_CNT_L;
    wire sel_cmpa_l = io_req.addr == `TMR_ADDR_CMPA_L;
    wire sel_cmpb_l = io_req.addr == `TMR_ADDR_CMPB_L;
    wire sel_cap_l  = io_req.addr == `TMR_ADDR_CAP_L;
    wire sel_high   = io_req.addr == `TMR_ADDR_CNT_H || io_req.addr == `TMR_ADDR_CMPA_H ||
                      io_req.addr == `TMR_ADDR_CMPB_H || io_req.addr == `TMR_ADDR_CAP_H;
    wire wr_gsync   = wr && io_req.addr == `TMR_ADDR_GSYNC;
    wire wr_flag    = wr && io_req.addr == `TMR_ADDR_FLAG;
    wire cnt_lo_wr  = wr && sel_cnt_l;
    wire cap_lo_wr  = wr && sel_cap_l;
    wire [1:0] cmp_lo_wr = {wr && sel_cmpb_l, wr && sel_cmpa_l};

    // Mode decode and TOP selection
    wire [3:0] mode = {timer_control_b[`TMR_CB_MODE_MSB:`TMR_CB_MODE_LSB],
                       timer_control_a[`TMR_CA_MODE_MSB:0]};
    wire [2:0] clock_select_field = timer_control_b[`TMR_CB_CS_MSB:0];
    wire pwm_mode = mode == `TMR_MODE_FPWM8 || mode == `TMR_MODE_FPWM9 ||
                    mode == `TMR_MODE_FPWM10 || mode == `TMR_MODE_FPWM_CAP ||
                    mode == `TMR_MODE_FPWM_CMP;
    wire ctc_mode = mode == `TMR_MODE_CTC_CMP || mode == `TMR_MODE_CTC_CAP;
    wire cap_is_top = mode == `TMR_MODE_CTC_CAP || mode == `TMR_MODE_FPWM_CAP;
    assign top_value = (mode == `TMR_MODE_FPWM8)  ? `TMR_TOP8 :
                       (mode == `TMR_MODE_FPWM9)  ? `TMR_TOP9 :
                       (mode == `TMR_MODE_FPWM10) ? `TMR_TOP10 :
                       (mode == `TMR_MODE_CTC_CMP || mode == `TMR_MODE_FPWM_CMP) ? compare_act[0] :
                       cap_is_top ? capture_value : `TMR_MAX;
    wire at_top    = counter_value == top_value;
    wire at_max    = counter_value == `TMR_MAX;
    wire wrap_top  = at_top && (pwm_mode || ctc_mode);

    // Shared prescaler
    tmr_prescaler u_prescaler (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .prescaler_rst (sync_prescaler_rst),
        .tap_tick      (tap_tick)
    );

    // External count pin sampling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_count_pin};
        end
    end

    // Timer tick selection
    wire ext_rise = ext_sync[1] & ~ext_sync[2];
    wire ext_fall = ~ext_sync[1] & ext_sync[2];
    wire sel_tick = (clock_select_field == `TMR_CS_DIRECT)   ? 1'b1 :
                    (clock_select_field == `TMR_CS_DIV8)     ? tap_tick[0] :
                    (clock_select_field == `TMR_CS_DIV64)    ? tap_tick[1] :
                    (clock_select_field == `TMR_CS_DIV256)   ? tap_tick[2] :
                    (clock_select_field == `TMR_CS_DIV1024)  ? tap_tick[3] :
                    (clock_select_field == `TMR_CS_EXT_FALL) ? ext_fall :
                    (clock_select_field == `TMR_CS_EXT_RISE) ? ext_rise : 1'b0;
    wire timer_tick = sel_tick && !timer_power_off;

    // Capture source, filter and edge
    logic cap_event;
    tmr_capture_filter u_capture (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .raw_in        (capture_use_comparator ? comparator_out : capture_input_pin),
        .noise_cancel  (timer_control_b[`TMR_CB_NOISE]),
        .rising_edge   (timer_control_b[`TMR_CB_EDGE]),
        .capture_event (cap_event)
    );
    wire cap_take = cap_event && !cap_is_top;

    // Counter next value, CPU write first
    always_comb begin
        next_counter = counter_value;
        if (cnt_lo_wr) begin
            next_counter = {high_hold, io_req.wdata};
        end else if (timer_tick && wrap_top) begin
            next_counter = `TMR_BOTTOM;
        end else if (timer_tick) begin
            next_counter = 16'(counter_value + 16'h0001);
        end
    end

    // Counter, capture and holding register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter_value <= `TMR_RST_WORD;
            capture_value <= `TMR_RST_WORD;
            high_hold     <= `TMR_RST_BYTE;
        end else begin
            counter_value <= next_counter;
            if (cap_lo_wr) begin
                capture_value <= {high_hold, io_req.wdata};
            end else if (cap_take) begin
                capture_value <= counter_value;
            end
            if (wr && sel_high) begin
                high_hold <= io_req.wdata;
            end else if (rd && sel_cnt_l) begin
                high_hold <= counter_value[15:8];
            end else if (rd && sel_cap_l) begin
                high_hold <= capture_value[15:8];
            end
        end
    end

    // Compare channels: buffer, active copy, match and waveform
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        wire [1:0] com = timer_control_a[`TMR_CA_COM_MSB-2*i -: 2];
        wire top_owner = (i == 0) && mode == `TMR_MODE_FPWM_CMP;
        assign cmp_match[i] = timer_tick && !cnt_lo_wr && counter_value == compare_act[i];

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                compare_buf[i] <= `TMR_RST_WORD;
                compare_act[i] <= `TMR_RST_WORD;
                wave[i]        <= 1'b0;
            end else begin
                if (cmp_lo_wr[i]) begin
                    compare_buf[i] <= {high_hold, io_req.wdata};
                end
                if (!pwm_mode || (timer_tick && at_top)) begin
                    compare_act[i] <= compare_buf[i];
                end
                if (top_owner) begin
                    wave[i] <= wave[i];
                end else if (pwm_mode && timer_tick && at_top && com[1]) begin
                    wave[i] <= ~com[0];
                end else if (cmp_match[i] && pwm_mode && com[1]) begin
                    wave[i] <= com[0];
                end else if (cmp_match[i] && !pwm_mode && com != 2'b00) begin
                    wave[i] <= com[1] ? com[0] : ~wave[i];
                end
            end
        end
    end

    // Flag set events; a set beats a same-cycle clear
    wire ovf_evt = timer_tick && !cnt_lo_wr && (pwm_mode ? at_top : at_max);
    wire [7:0] set_vec = {2'b00, cap_take, 2'b00, cmp_match[1], cmp_match[0], ovf_evt};
    wire [7:0] clr_vec = wr_flag ? io_req.wdata : 8'h00;
    assign next_flag = ((timer_flag_register & ~clr_vec) | set_vec) & `TMR_FLAG_BITS;

    // Control, flag, mask and masked requests
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_control_a     <= `TMR_RST_BYTE;
            timer_control_b     <= `TMR_RST_BYTE;
            timer_flag_register <= `TMR_RST_BYTE;
            timer_mask_register <= `TMR_RST_BYTE;
            irq_req             <= 4'h0;
        end else begin
            timer_flag_register <= next_flag;
            if (wr && io_req.addr == `TMR_ADDR_CTRL_A) begin
                timer_control_a <= io_req.wdata & `TMR_CTRL_A_BITS;
            end
            if (wr && io_req.addr == `TMR_ADDR_CTRL_B) begin
                timer_control_b <= io_req.wdata & `TMR_CTRL_B_BITS;
            end
            if (wr && io_req.addr == `TMR_ADDR_MASK) begin
                timer_mask_register <= io_req.wdata & `TMR_FLAG_BITS;
            end
            irq_req <= {timer_flag_register[`TMR_FLAG_CAP]  & timer_mask_register[`TMR_FLAG_CAP],
                        timer_flag_register[`TMR_FLAG_CMPB] & timer_mask_register[`TMR_FLAG_CMPB],
                        timer_flag_register[`TMR_FLAG_CMPA] & timer_mask_register[`TMR_FLAG_CMPA],
                        timer_flag_register[`TMR_FLAG_OVF]  & timer_mask_register[`TMR_FLAG_OVF]};
        end
    end

    // General sync control: hold keeps bits, otherwise they self-clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_hold_mode      <= 1'b0;
            sync_prescaler_rst  <= 1'b0;
            async_prescaler_rst <= 1'b0;
        end else if (wr_gsync) begin
            sync_hold_mode      <= io_req.wdata[`TMR_GT_HOLD];
            sync_prescaler_rst  <= io_req.wdata[`TMR_GT_SYNC];
            async_prescaler_rst <= io_req.wdata[`TMR_GT_ASYNC];
        end else if (!sync_hold_mode) begin
            sync_prescaler_rst  <= 1'b0;
            async_prescaler_rst <= 1'b0;
        end
    end

    // Read selection
    always_comb begin
        if (io_req.addr == `TMR_ADDR_CTRL_A) begin
            read_data = timer_control_a;
        end else if (io_req.addr == `TMR_ADDR_CTRL_B) begin
            read_data = timer_control_b;
        end else if (sel_cnt_l) begin
            read_data = counter_value[7:0];
        end else if (io_req.addr == `TMR_ADDR_CNT_H || io_req.addr == `TMR_ADDR_CAP_H) begin
            read_data = high_hold;
        end else if (sel_cmpa_l) begin
            read_data = compare_buf[0][7:0];
        end else if (io_req.addr == `TMR_ADDR_CMPA_H) begin
            read_data = compare_buf[0][15:8];
        end else if (sel_cmpb_l) begin
            read_data = compare_buf[1][7:0];
        end else if (io_req.addr == `TMR_ADDR_CMPB_H) begin
            read_data = compare_buf[1][15:8];
        end else if (sel_cap_l) begin
            read_data = capture_value[7:0];
        end else if (io_req.addr == `TMR_ADDR_FLAG) begin
            read_data = timer_flag_register;
        end else if (io_req.addr == `TMR_ADDR_MASK) begin
            read_data = timer_mask_register;
        end else if (io_req.addr == `TMR_ADDR_GSYNC) begin
            read_data = {sync_hold_mode, 5'h00, async_prescaler_rst, sync_prescaler_rst};
        end else begin
            read_data = 8'h00;
        end
    end

    // Read data register and waveform outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_rdata       <= 8'h00;
            waveform_out_a <= 1'b0;
            waveform_out_b <= 1'b0;
        end else begin
            if (rd) begin
                io_rdata <= read_data;
            end
            waveform_out_a <= wave[0];
            waveform_out_b <= wave[1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    hold_keep_a: assert property (sync_hold_mode && !wr_gsync |=>
                                  $stable(sync_prescaler_rst) && $stable(async_prescaler_rst))
        else $error("prescaler reset bits changed in hold mode");
    hold_release_a: assert property ((wr_gsync && !io_req.wdata[`TMR_GT_HOLD]) ##1 !wr_gsync
                                     |=> !sync_prescaler_rst && !async_prescaler_rst)
        else $error("reset bits not cleared after hold release");
    self_clear_a: assert property (sync_prescaler_rst && !sync_hold_mode && !wr_gsync
                                   |=> !sync_prescaler_rst)
        else $error("sync prescaler reset did not self-clear");
    low_write_a: assert property (cnt_lo_wr |=>
                                  counter_value == {$past(high_hold), $past(io_req.wdata)})
        else $error("counter write did not load held high byte");
    low_read_a: assert property (rd && sel_cnt_l && !wr |=>
                                 high_hold == $past(counter_value[15:8]))
        else $error("low read did not latch high byte");
    cmp_high_a: assert property (rd && !wr && io_req.addr == `TMR_ADDR_CMPA_H |=>
                                 io_rdata == $past(compare_buf[0][15:8]) && $stable(high_hold))
        else $error("compare high read used holding register");
    stop_hold_a: assert property (clock_select_field == `TMR_CS_OFF && !cnt_lo_wr
                                  |=> $stable(counter_value))
        else $error("counter moved with no clock selected");
    max_wrap_a: assert property (timer_tick && at_max && !pwm_mode && !cnt_lo_wr
                                 |=> counter_value == `TMR_BOTTOM && timer_flag_register[0])
        else $error("MAX did not wrap to BOTTOM with overflow flag");
    match_flag_a: assert property (cmp_match[0] |=> timer_flag_register[`TMR_FLAG_CMPA]
                                   ##1 irq_req[1] == $past(timer_mask_register[`TMR_FLAG_CMPA]))
        else $error("compare match flag or request missing");
    capture_take_a: assert property (cap_take && !cap_lo_wr |=>
                                     capture_value == $past(counter_value))
        else $error("capture did not store counter value");
    gt_zero_a: assert property (rd && io_req.addr == `TMR_ADDR_GSYNC |=>
                                io_rdata[6:2] == 5'h00)
        else $error("reserved sync control bits read nonzero");
endmodule

// ==== src/tmr_defs.svh ====
// Register indices, field positions, reset values and count limits of the timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Byte register indices on the 8-bit I/O port
`define TMR_ADDR_CTRL_A   4'h0
`define TMR_ADDR_CTRL_B   4'h1
`define TMR_ADDR_CNT_L    4'h2
`define TMR_ADDR_CNT_H    4'h3
`define TMR_ADDR_CMPA_L   4'h4
`define TMR_ADDR_CMPA_H   4'h5
`define TMR_ADDR_CMPB_L   4'h6
`define TMR_ADDR_CMPB_H   4'h7
`define TMR_ADDR_CAP_L    4'h8
`define TMR_ADDR_CAP_H    4'h9
`define TMR_ADDR_FLAG     4'hA
`define TMR_ADDR_MASK     4'hB
`define TMR_ADDR_GSYNC    4'hC

// Reset values
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      16'h0000

// Writable bit masks
`define TMR_CTRL_A_BITS   8'hF3
`define TMR_CTRL_B_BITS   8'hDF
`define TMR_FLAG_BITS     8'h27

// Flag and mask bit positions
`define TMR_FLAG_OVF      0
`define TMR_FLAG_CMPA     1
`define TMR_FLAG_CMPB     2
`define TMR_FLAG_CAP      5

// General sync control bit positions
`define TMR_GT_HOLD       7
`define TMR_GT_ASYNC      1
`define TMR_GT_SYNC       0

// Control field positions
`define TMR_CA_COM_MSB    7
`define TMR_CA_MODE_MSB   1
`define TMR_CB_NOISE      7
`define TMR_CB_EDGE       6
`define TMR_CB_MODE_MSB   4
`define TMR_CB_MODE_LSB   3
`define TMR_CB_CS_MSB     2

// Clock select codes
`define TMR_CS_OFF        3'h0
`define TMR_CS_DIRECT     3'h1
`define TMR_CS_DIV8       3'h2
`define TMR_CS_DIV64      3'h3
`define TMR_CS_DIV256     3'h4
`define TMR_CS_DIV1024    3'h5
`define TMR_CS_EXT_FALL   3'h6
`define TMR_CS_EXT_RISE   3'h7

// Operating mode codes
`define TMR_MODE_CTC_CMP  4'h4
`define TMR_MODE_FPWM8    4'h5
`define TMR_MODE_FPWM9    4'h6
`define TMR_MODE_FPWM10   4'h7
`define TMR_MODE_CTC_CAP  4'hC
`define TMR_MODE_FPWM_CAP 4'hE
`define TMR_MODE_FPWM_CMP 4'hF

// Count limits
`define TMR_BOTTOM        16'h0000
`define TMR_MAX           16'hFFFF
`define TMR_TOP8          16'h00FF
`define TMR_TOP9          16'h01FF
`define TMR_TOP10         16'h03FF

// Prescaler tap widths: divide by 8, 64, 256, 1024
`define TMR_PS_WIDTH      10
`define TMR_PS_MSB_DIV8   2
`define TMR_PS_MSB_DIV64  5
`define TMR_PS_MSB_DIV256 7

`endif

// ==== src/tmr_pkg.sv ====
// Types shared by the timer modules
package tmr_pkg;
    // One CPU access on the 8-bit I/O port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tmr_io_req_t;

    typedef logic [15:0] tmr_word_t;
endpackage

// ==== src/tmr_prescaler.sv ====
// Free running shared prescaler with four tap pulses
`include "tmr_defs.svh"
module tmr_prescaler (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       prescaler_rst,
    // Tap pulses: div8, div64, div256, div1024
    output logic [3:0]      tap_tick
);
    logic [`TMR_PS_WIDTH-1:0] div_count;

    // Counter held at zero while reset is asserted
    always_ff @(posedge clk) begin
        if (sys_rst || prescaler_rst) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 1'b1;
        end
    end

    // Taps fire on the last count of each period
    assign tap_tick[0] = &div_count[`TMR_PS_MSB_DIV8:0];
    assign tap_tick[1] = &div_count[`TMR_PS_MSB_DIV64:0];
    assign tap_tick[2] = &div_count[`TMR_PS_MSB_DIV256:0];
    assign tap_tick[3] = &div_count;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    tap_halt_a: assert property (prescaler_rst |=> tap_tick == 4'h0)
        else $error("prescaler tap fired while held in reset");
endmodule

// ==== src/tmr_capture_filter.sv ====
// Capture input noise canceler and edge detector
module tmr_capture_filter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Source and options
    input  wire logic raw_in,
    input  wire logic noise_cancel,
    input  wire logic rising_edge,
    // Event
    output logic      capture_event
);
    logic       in_q;
    logic [3:0] history;
    logic       filtered;
    logic       filtered_q;

    // Sampling, four-sample history and filtered level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_q       <= 1'b0;
            history    <= 4'h0;
            filtered   <= 1'b0;
            filtered_q <= 1'b0;
        end else begin
            in_q       <= raw_in;
            history    <= {history[2:0], in_q};
            filtered_q <= filtered;
            if (!noise_cancel) begin
                filtered <= in_q;
            end else if (&history) begin
                filtered <= 1'b1;
            end else if (~|history) begin
                filtered <= 1'b0;
            end
        end
    end

    // Selected edge of the filtered level
    assign capture_event = rising_edge ? (filtered & ~filtered_q) : (~filtered & filtered_q);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    spike_block_a: assert property (noise_cancel && !(&history) && !(~|history)
                                    |=> $stable(filtered))
        else $error("filtered level moved on a mixed history");
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the timer register port and prescaler sync control
`include "tmr_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk;
    logic                 sys_rst;
    tmr_pkg::tmr_io_req_t io_req;
    logic [7:0]           io_rdata;
    logic                 ext_pin;
    logic                 cap_pin;
    logic                 cmp_out;
    logic                 use_cmp;
    logic                 pwr_off;
    logic                 wave_a;
    logic                 wave_b;
    logic [3:0]           irq_req;
    logic                 sync_rst;
    logic                 async_rst;
    logic [7:0]           rv;
    int                   fails;
    int                   comparisons;
    int                   n;

    tmr_timer16 dut_u (.clk(clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
        .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
        .capture_use_comparator(use_cmp), .timer_power_off(pwr_off), .waveform_out_a(wave_a),
        .waveform_out_b(wave_b), .irq_req(irq_req), .sync_prescaler_rst(sync_rst),
        .async_prescaler_rst(async_rst));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One byte write, then one idle cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        io_req = '0;
        @(negedge clk);
    endtask

    // One byte read, data taken one cycle later
    task automatic rd(input logic [3:0] a);
        io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        rv = io_rdata;
        io_req = '0;
        @(negedge clk);
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        io_req = '0;
        {ext_pin, cap_pin, cmp_out, use_cmp, pwr_off} = '0;
        fails = 0;
        comparisons = 0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        // Reset values, unmapped index included
        for (int a = 0; a < 14; a++) begin
            rd(4'(a));
            chk(16'(rv), 16'h0000);
        end
        // Hold mode keeps both reset bits, unused bits read zero
        wr(`TMR_ADDR_GSYNC, 8'hFF);
        repeat (3) @(negedge clk);
        chk(16'({sync_rst, async_rst}), 16'h0003);
        rd(`TMR_ADDR_GSYNC);
        chk(16'(rv), 16'h0083);
        wr(`TMR_ADDR_GSYNC, 8'h03);
        chk(16'({sync_rst, async_rst}), 16'h0000);
        // Sync reset bit is a one-cycle pulse outside hold mode
        io_req = '{wr: 1'b1, rd: 1'b0, addr: `TMR_ADDR_GSYNC, wdata: 8'h01};
        @(negedge clk);
        io_req = '0;
        chk(16'(sync_rst), 16'h0001);
        @(negedge clk);
        chk(16'(sync_rst), 16'h0000);
        wr(`TMR_ADDR_GSYNC, 8'h02);
        chk(16'(async_rst), 16'h0000);
        // Stopped counter written high then low, read low then high
        wr(`TMR_ADDR_CNT_H, 8'h01);
        wr(`TMR_ADDR_CNT_L, 8'hFF);
        rd(`TMR_ADDR_CNT_L);
        chk(16'(rv), 16'h00FF);
        rd(`TMR_ADDR_CNT_H);
        chk(16'(rv), 16'h0001);
        // One held byte serves two registers; compare high bypasses it
        wr(`TMR_ADDR_CMPA_H, 8'hAB);
        wr(`TMR_ADDR_CMPA_L, 8'h05);
        wr(`TMR_ADDR_CMPB_L, 8'h07);
        wr(`TMR_ADDR_CAP_H, 8'h55);
        rd(`TMR_ADDR_CMPB_H);
        chk(16'(rv), 16'h00AB);
        rd(`TMR_ADDR_CAP_H);
        chk(16'(rv), 16'h0055);
        // Compare match sets the flag; request follows only when unmasked
        wr(`TMR_ADDR_CMPA_H, 8'h00);
        wr(`TMR_ADDR_CMPA_L, 8'h05);
        wr(`TMR_ADDR_CNT_L, 8'h00);
        wr(`TMR_ADDR_CTRL_A, 8'h40);
        wr(`TMR_ADDR_CTRL_B, 8'h01);
        n = 0;
        rv = 8'h00;
        while (rv[1] !== 1'b1 && n < 40) begin
            rd(`TMR_ADDR_FLAG);
            n++;
        end
        if (rv[1] !== 1'b1) begin
            fails++;
            close_out();
        end
        chk(16'(irq_req), 16'h0000);
        wr(`TMR_ADDR_MASK, 8'h02);
        repeat (2) @(negedge clk);
        chk(16'(irq_req), 16'h0002);
        chk(16'({wave_b, wave_a}), 16'h0001);
        wr(`TMR_ADDR_CTRL_B, 8'h00);
        wr(`TMR_ADDR_FLAG, 8'h02);
        repeat (2) @(negedge clk);
        rd(`TMR_ADDR_FLAG);
        chk({4'h0, rv & 8'h02, irq_req}, 16'h0000);
        // Rising edge on the capture pin stores the stopped counter
        wr(`TMR_ADDR_CNT_H, 8'h12);
        wr(`TMR_ADDR_CNT_L, 8'h34);
        wr(`TMR_ADDR_CTRL_B, 8'h40);
        cap_pin = 1'b1;
        repeat (4) @(negedge clk);
        rd(`TMR_ADDR_CAP_L);
        chk(16'(rv), 16'h0034);
        rd(`TMR_ADDR_CAP_H);
        chk(16'(rv), 16'h0012);
        rd(`TMR_ADDR_FLAG);
        chk(16'(rv), 16'h0020);
        // Count through MAX wraps to BOTTOM and sets overflow
        wr(`TMR_ADDR_CNT_H, 8'hFF);
        wr(`TMR_ADDR_CNT_L, 8'hFE);
        wr(`TMR_ADDR_CTRL_B, 8'h41);
        repeat (2) @(negedge clk);
        rd(`TMR_ADDR_FLAG);
        chk(16'(rv & 8'h01), 16'h0001);
        close_out();
    end
endmodule
